//--- logic/tpc_touch_panel.v
// Touch panel command interpreter, report framer and report FIFO
// Overview of operation
// - Commands 65h/67h turn display and backlight on
// - Commands 66h/68h turn display and backlight off
// - Touch never restores a commanded-off display
// - 69h enables, 6Ah disables high click
// - 6Bh enables, 6Ch disables low click
// - 71h starts, 72h stops high buzzer
// - 73h starts, 74h stops low buzzer
// - One sound at a time, fixed priority
// - Off clears own source; next one sounds
// - Buffers empty at power-up before traffic
// - Serial link is 9600 baud 8N1
// - Power-up: display, backlight on, buzzers off
// - Auto and click switches sampled once at power-on; port switch followed continuously
// - One-byte commands act regardless of auto and click switches
// - X and Y are 10-bit, origin upper left
// - Touched frame: 11h, X two bytes, Y two
// - Touched frames repeat while panel pressed
// - One 10h frame with last position on release
// - At most 87 reports per second
// - Port switch selects USB or serial port
// - Auto mode darkens backlight after 5 idle minutes
// - Display command disables auto backlight-off mode
`include "tpc_defs.vh"

module tpc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire ref_clk,
	input wire rstn,
	// Fill side
	input wire [WIDTH-1:0] inData,
	input wire inValid,
	output wire inReady,
	// Drain side
	output wire [WIDTH-1:0] outData,
	output wire outValid,
	input wire outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_q;
	reg [AW-1:0] rdPtr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	assign inReady = (count_q != DEPTH);
	assign outValid = (count_q != 0);
	assign outData = mem[rdPtr_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always @(posedge ref_clk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule

module tpc_touch_panel #(
	parameter [`TPC_TIMER_W-1:0] REPORT_CYC = `TPC_REPORT_CYC,
	parameter [`TPC_TIMER_W-1:0] IDLE_CYC = `TPC_IDLE_CYC,
	parameter [`TPC_TIMER_W-1:0] CLICK_CYC = `TPC_CLICK_CYC
) (
	// Clock and reset
	input wire ref_clk,
	input wire rstn,
	// Setup switches
	input wire autoBacklightOffSwitch,
	input wire clickDefaultSwitch,
	input wire reportPortSelectSwitch,
	// Touch sensor
	input wire touchPressed,
	input wire [`TPC_COORD_W-1:0] touchX,
	input wire [`TPC_COORD_W-1:0] touchY,
	// Host serial link pins
	input wire serialRx,
	output wire serialTx,
	// USB byte port
	input wire [7:0] usbRxData,
	input wire usbRxValid,
	output wire [7:0] usbTxData,
	output wire usbTxValid,
	input wire usbTxReady,
	// Display and sound outputs
	output wire displayOn,
	output wire backlightOn,
	output wire buzzerHighOn,
	output wire buzzerLowOn,
	output wire clickHighOn,
	output wire clickLowOn
);
	localparam RX_IDLE = 2'd0;
	localparam RX_START = 2'd1;
	localparam RX_DATA = 2'd2;
	localparam RX_STOP = 2'd3;
	localparam GEN_WAIT = 1'b0;
	localparam GEN_SEND = 1'b1;

	reg [1:0] swMeta_q, swSync_q;
	reg [1:0] initCnt_q;
	reg portMeta_q, portUsb_q;
	reg pressMeta_q, pressSync_q, pressPrev_q;
	reg [`TPC_COORD_W-1:0] xMeta_q, xSync_q, yMeta_q, ySync_q;
	reg rxMeta_q, rxSync_q;
	reg [1:0] rxState_q;
	reg [`TPC_BIT_CNT_W-1:0] rxCnt_q;
	reg [2:0] rxBit_q;
	reg [7:0] rxShift_q;
	reg uartCmdValid_q;
	reg [7:0] uartCmd_q;
	reg displayOn_q, dark_q, autoMode_q, backlightOn_q;
	reg buzHi_q, buzLo_q, clkHi_q, clkLo_q;
	reg [`TPC_TIMER_W-1:0] idleCnt_q, clickCnt_q, rateCnt_q;
	reg [3:0] sound_q;
	reg genState_q, genTouched_q;
	reg [2:0] genIdx_q;
	reg [`TPC_COORD_W-1:0] lastX_q, lastY_q;
	reg pendRelease_q;
	reg [9:0] txShift_q;
	reg [3:0] txLeft_q;
	reg [`TPC_BIT_CNT_W-1:0] txCnt_q;
	reg [7:0] usbTxData_q;
	reg usbTxValid_q;
	reg [7:0] genByte;
	reg [3:0] soundNext;
	wire initDone, cmdValid;
	wire [7:0] cmdByte;
	wire fifoInReady, fifoOutValid, fifoOutReady;
	wire [7:0] fifoOutData;
	wire activity, clickSounding;

	assign initDone = (initCnt_q == `TPC_INIT_DONE);
	assign serialTx = txShift_q[0];
	assign usbTxData = usbTxData_q;
	assign usbTxValid = usbTxValid_q;
	assign displayOn = displayOn_q;
	assign backlightOn = backlightOn_q;
	assign buzzerHighOn = sound_q[3];
	assign buzzerLowOn = sound_q[2];
	assign clickHighOn = sound_q[1];
	assign clickLowOn = sound_q[0];

	// Pin synchronisers; auto and click switches caught once after reset, port switch always
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			swMeta_q <= 2'b00;
			swSync_q <= 2'b00;
			pressMeta_q <= 1'b0;
			pressSync_q <= 1'b0;
			xMeta_q <= {`TPC_COORD_W{1'b0}};
			xSync_q <= {`TPC_COORD_W{1'b0}};
			yMeta_q <= {`TPC_COORD_W{1'b0}};
			ySync_q <= {`TPC_COORD_W{1'b0}};
			rxMeta_q <= 1'b1;
			rxSync_q <= 1'b1;
			portMeta_q <= 1'b0;
			portUsb_q <= 1'b0;
			initCnt_q <= 2'b00;
		end else begin
			swMeta_q <= {autoBacklightOffSwitch, clickDefaultSwitch};
			swSync_q <= swMeta_q;
			pressMeta_q <= touchPressed;
			pressSync_q <= pressMeta_q;
			xMeta_q <= touchX;
			xSync_q <= xMeta_q;
			yMeta_q <= touchY;
			ySync_q <= yMeta_q;
			rxMeta_q <= serialRx;
			rxSync_q <= rxMeta_q;
			portMeta_q <= reportPortSelectSwitch;
			portUsb_q <= portMeta_q;
			if (!initDone) begin
				initCnt_q <= initCnt_q + 1'b1;
			end
		end
	end

	// Serial receiver, 8N1 at the fixed baud rate
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rxState_q <= RX_IDLE;
			rxCnt_q <= {`TPC_BIT_CNT_W{1'b0}};
			rxBit_q <= 3'd0;
			rxShift_q <= 8'h00;
			uartCmdValid_q <= 1'b0;
			uartCmd_q <= 8'h00;
		end else begin
			uartCmdValid_q <= 1'b0;
			case (rxState_q)
			RX_IDLE: begin
				rxCnt_q <= {`TPC_BIT_CNT_W{1'b0}};
				if (!rxSync_q && initDone) begin
					rxState_q <= RX_START;
				end
			end
			RX_START: begin
				if (rxCnt_q == `TPC_HALF_BIT_CYC) begin
					rxCnt_q <= {`TPC_BIT_CNT_W{1'b0}};
					rxBit_q <= 3'd0;
					rxState_q <= rxSync_q ? RX_IDLE : RX_DATA;
				end else begin
					rxCnt_q <= rxCnt_q + 1'b1;
				end
			end
			RX_DATA: begin
				if (rxCnt_q == `TPC_BIT_CYC - 1) begin
					rxCnt_q <= {`TPC_BIT_CNT_W{1'b0}};
					rxShift_q <= {rxSync_q, rxShift_q[7:1]};
					rxBit_q <= rxBit_q + 1'b1;
					if (rxBit_q == `TPC_LAST_DATA_BIT) begin
						rxState_q <= RX_STOP;
					end
				end else begin
					rxCnt_q <= rxCnt_q + 1'b1;
				end
			end
			RX_STOP: begin
				if (rxCnt_q == `TPC_BIT_CYC - 1) begin
					rxState_q <= RX_IDLE;
					uartCmdValid_q <= rxSync_q;
					uartCmd_q <= rxShift_q;
				end else begin
					rxCnt_q <= rxCnt_q + 1'b1;
				end
			end
			default: rxState_q <= RX_IDLE;
			endcase
		end
	end

	// Commands come from the selected port only
	assign cmdValid = initDone &&
		(portUsb_q ? usbRxValid : uartCmdValid_q);
	assign cmdByte = portUsb_q ? usbRxData : uartCmd_q;
	assign activity = cmdValid || pressSync_q;
	assign clickSounding = (clickCnt_q != {`TPC_TIMER_W{1'b0}});

	// Command interpreter and backlight control
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			displayOn_q <= 1'b1;
			backlightOn_q <= 1'b1;
			dark_q <= 1'b0;
			autoMode_q <= 1'b0;
			buzHi_q <= 1'b0;
			buzLo_q <= 1'b0;
			clkHi_q <= 1'b0;
			clkLo_q <= 1'b0;
			idleCnt_q <= {`TPC_TIMER_W{1'b0}};
		end else begin
			if (initCnt_q == `TPC_INIT_CAPTURE) begin
				autoMode_q <= swSync_q[1];
				clkHi_q <= swSync_q[0];
			end
			if (cmdValid) begin
				case (cmdByte)
				`TPC_CMD_DISP_ON_A, `TPC_CMD_DISP_ON_B: begin
					displayOn_q <= 1'b1;
					autoMode_q <= 1'b0;
				end
				`TPC_CMD_DISP_OFF_A, `TPC_CMD_DISP_OFF_B: begin
					displayOn_q <= 1'b0;
					autoMode_q <= 1'b0;
				end
				`TPC_CMD_CLICK_HI_ON: clkHi_q <= 1'b1;
				`TPC_CMD_CLICK_HI_OFF: clkHi_q <= 1'b0;
				`TPC_CMD_CLICK_LO_ON: clkLo_q <= 1'b1;
				`TPC_CMD_CLICK_LO_OFF: clkLo_q <= 1'b0;
				`TPC_CMD_BUZ_HI_ON: buzHi_q <= 1'b1;
				`TPC_CMD_BUZ_HI_OFF: buzHi_q <= 1'b0;
				`TPC_CMD_BUZ_LO_ON: buzLo_q <= 1'b1;
				`TPC_CMD_BUZ_LO_OFF: buzLo_q <= 1'b0;
				default: displayOn_q <= displayOn_q;
				endcase
			end
			if (activity) begin
				idleCnt_q <= {`TPC_TIMER_W{1'b0}};
				dark_q <= 1'b0;
			end else if (idleCnt_q >= IDLE_CYC - 1'b1) begin
				dark_q <= autoMode_q;
			end else begin
				idleCnt_q <= idleCnt_q + 1'b1;
			end
			// Touch only lifts auto darkness, never display-off
			backlightOn_q <= displayOn_q && !dark_q;
		end
	end

	// Sound arbitration, highest enabled source wins
	always @* begin
		soundNext = 4'b0000;
		if (buzHi_q) begin
			soundNext = 4'b1000;
		end else if (buzLo_q) begin
			soundNext = 4'b0100;
		end else if (clkHi_q && clickSounding) begin
			soundNext = 4'b0010;
		end else if (clkLo_q && clickSounding) begin
			soundNext = 4'b0001;
		end
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sound_q <= 4'b0000;
			clickCnt_q <= {`TPC_TIMER_W{1'b0}};
			pressPrev_q <= 1'b0;
		end else begin
			sound_q <= soundNext;
			pressPrev_q <= pressSync_q;
			if (pressSync_q && !pressPrev_q) begin
				clickCnt_q <= CLICK_CYC;
			end else if (clickSounding) begin
				clickCnt_q <= clickCnt_q - 1'b1;
			end
		end
	end

	// Report framer: rate-limited touched and release frames
	always @* begin
		case (genIdx_q)
		3'd0: genByte = genTouched_q ? `TPC_HDR_TOUCHED
			: `TPC_HDR_RELEASED;
		3'd1: genByte = {`TPC_COORD_PAD, lastX_q[9:8]};
		3'd2: genByte = lastX_q[7:0];
		3'd3: genByte = {`TPC_COORD_PAD, lastY_q[9:8]};
		default: genByte = lastY_q[7:0];
		endcase
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			genState_q <= GEN_WAIT;
			genTouched_q <= 1'b0;
			genIdx_q <= 3'd0;
			lastX_q <= {`TPC_COORD_W{1'b0}};
			lastY_q <= {`TPC_COORD_W{1'b0}};
			pendRelease_q <= 1'b0;
			rateCnt_q <= {`TPC_TIMER_W{1'b0}};
		end else begin
			if (rateCnt_q != {`TPC_TIMER_W{1'b0}}) begin
				rateCnt_q <= rateCnt_q - 1'b1;
			end
			if (pressPrev_q && !pressSync_q) begin
				pendRelease_q <= 1'b1;
			end
			case (genState_q)
			GEN_WAIT: begin
				genIdx_q <= 3'd0;
				if (initDone && rateCnt_q == {`TPC_TIMER_W{1'b0}}) begin
					if (pressSync_q) begin
						lastX_q <= xSync_q;
						lastY_q <= ySync_q;
						genTouched_q <= 1'b1;
						pendRelease_q <= 1'b0;
						genState_q <= GEN_SEND;
						rateCnt_q <= REPORT_CYC - 1'b1;
					end else if (pendRelease_q) begin
						genTouched_q <= 1'b0;
						pendRelease_q <= 1'b0;
						genState_q <= GEN_SEND;
						rateCnt_q <= REPORT_CYC - 1'b1;
					end
				end
			end
			GEN_SEND: begin
				if (fifoInReady) begin
					genIdx_q <= genIdx_q + 1'b1;
					if (genIdx_q == `TPC_FRAME_LAST) begin
						genState_q <= GEN_WAIT;
					end
				end
			end
			default: genState_q <= GEN_WAIT;
			endcase
		end
	end

	tpc_fifo #(
		.WIDTH(8),
		.DEPTH(`TPC_FIFO_DEPTH),
		.AW(`TPC_FIFO_AW)
	) reportFifo (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.inData(genByte),
		.inValid(genState_q == GEN_SEND),
		.inReady(fifoInReady),
		.outData(fifoOutData),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady)
	);

	// Drain to the selected port
	assign fifoOutReady = portUsb_q ? (!usbTxValid_q || usbTxReady)
		: (txLeft_q == 4'd0);

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			txShift_q <= 10'h3ff;
			txLeft_q <= 4'd0;
			txCnt_q <= {`TPC_BIT_CNT_W{1'b0}};
			usbTxData_q <= 8'h00;
			usbTxValid_q <= 1'b0;
		end else begin
			if (usbTxValid_q && usbTxReady) begin
				usbTxValid_q <= 1'b0;
			end
			if (fifoOutValid && fifoOutReady && portUsb_q) begin
				usbTxData_q <= fifoOutData;
				usbTxValid_q <= 1'b1;
			end
			if (fifoOutValid && fifoOutReady && !portUsb_q) begin
				txShift_q <= {1'b1, fifoOutData, 1'b0};
				txLeft_q <= `TPC_FRAME_BITS;
				txCnt_q <= {`TPC_BIT_CNT_W{1'b0}};
			end else if (txLeft_q != 4'd0) begin
				if (txCnt_q == `TPC_BIT_CYC - 1) begin
					txCnt_q <= {`TPC_BIT_CNT_W{1'b0}};
					txShift_q <= {1'b1, txShift_q[9:1]};
					txLeft_q <= txLeft_q - 1'b1;
				end else begin
					txCnt_q <= txCnt_q + 1'b1;
				end
			end
		end
	end
endmodule

//--- include/tpc_defs.vh
// Constants for the touch panel command and report block
`ifndef TPC_DEFS_VH
`define TPC_DEFS_VH

// Clock and serial framing
`define TPC_CLK_HZ 20000000
`define TPC_BAUD 9600
`define TPC_DATA_BITS 8
`define TPC_BIT_CYC (`TPC_CLK_HZ / `TPC_BAUD)
`define TPC_HALF_BIT_CYC (`TPC_BIT_CYC / 2)
`define TPC_BIT_CNT_W 12
`define TPC_FRAME_BITS 4'd10
`define TPC_LAST_DATA_BIT 3'd7

// Host commands
`define TPC_CMD_DISP_ON_A 8'h65
`define TPC_CMD_DISP_OFF_A 8'h66
`define TPC_CMD_DISP_ON_B 8'h67
`define TPC_CMD_DISP_OFF_B 8'h68
`define TPC_CMD_CLICK_HI_ON 8'h69
`define TPC_CMD_CLICK_HI_OFF 8'h6a
`define TPC_CMD_CLICK_LO_ON 8'h6b
`define TPC_CMD_CLICK_LO_OFF 8'h6c
`define TPC_CMD_BUZ_HI_ON 8'h71
`define TPC_CMD_BUZ_HI_OFF 8'h72
`define TPC_CMD_BUZ_LO_ON 8'h73
`define TPC_CMD_BUZ_LO_OFF 8'h74

// Touch report format
`define TPC_HDR_TOUCHED 8'h11
`define TPC_HDR_RELEASED 8'h10
`define TPC_COORD_W 10
`define TPC_COORD_PAD 6'h00
`define TPC_FRAME_LAST 3'd4
`define TPC_FIFO_DEPTH 4
`define TPC_FIFO_AW 2

// Timing
`define TPC_RATE_MAX_HZ 87
`define TPC_REPORT_CYC (40'h0 + \
	(`TPC_CLK_HZ + `TPC_RATE_MAX_HZ - 1) / `TPC_RATE_MAX_HZ)
`define TPC_IDLE_MIN 5
`define TPC_IDLE_CYC (40'd60 * `TPC_IDLE_MIN * `TPC_CLK_HZ)
`define TPC_CLICK_MS 20
`define TPC_CLICK_CYC (40'h0 + `TPC_CLICK_MS * (`TPC_CLK_HZ / 1000))
`define TPC_TIMER_W 40
`define TPC_INIT_DONE 2'd3
`define TPC_INIT_CAPTURE 2'd2

`endif

//--- sim/tpc_touch_panel_asserts.sv
// Port-level assertions for the touch panel block
`include "tpc_defs.vh"
module tpc_touch_panel_asserts #(
	parameter [`TPC_TIMER_W-1:0] REPORT_CYC = `TPC_REPORT_CYC,
	parameter [`TPC_TIMER_W-1:0] IDLE_CYC = `TPC_IDLE_CYC,
	parameter [`TPC_TIMER_W-1:0] CLICK_CYC = `TPC_CLICK_CYC
) (
	// Clock and reset
	input wire ref_clk, rstn,
	// Switches and touch
	input wire autoBacklightOffSwitch, clickDefaultSwitch,
	input wire reportPortSelectSwitch, touchPressed,
	input wire [`TPC_COORD_W-1:0] touchX, touchY,
	// Links
	input wire serialRx, serialTx,
	input wire [7:0] usbRxData, usbTxData,
	input wire usbRxValid, usbTxValid, usbTxReady,
	// Display and sound
	input wire displayOn, backlightOn, buzzerHighOn,
	input wire buzzerLowOn, clickHighOn, clickLowOn
);
	logic [1:0] portQ;
	logic [2:0] initQ;
	wire [3:0] snd = {buzzerHighOn, buzzerLowOn, clickHighOn, clickLowOn};
	// Command taken on the USB port once init is over
	wire cmd = usbRxValid && reportPortSelectSwitch && (&portQ)
		&& initQ == 3'd5;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			portQ <= 2'b00;
			initQ <= 3'd0;
		end else begin
			portQ <= {portQ[0], reportPortSelectSwitch};
			if (initQ != 3'd5)
				initQ <= initQ + 3'd1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	reset_state_a: assert property ($rose(rstn) |-> displayOn && backlightOn
		&& snd == 4'h0) else $error("bad state after reset");
	disp_on_a: assert property (cmd && (usbRxData == 8'h65
		|| usbRxData == 8'h67) |-> ##[1:2] displayOn) else $error("display not on");
	disp_off_a: assert property (cmd && (usbRxData == 8'h66
		|| usbRxData == 8'h68) |-> ##[1:2] !displayOn) else $error("display not off");
	backlight_tie_a: assert property (backlightOn |-> $past(displayOn))
		else $error("backlight lit with display off");
	buz_hi_on_a: assert property (cmd && usbRxData == 8'h71 |-> ##2 buzzerHighOn)
		else $error("high buzzer not started");
	buz_hi_off_a: assert property (cmd && usbRxData == 8'h72 |-> ##2 !buzzerHighOn)
		else $error("high buzzer not stopped");
	buz_lo_on_a: assert property (cmd && usbRxData == 8'h73
		|-> ##2 (buzzerLowOn || buzzerHighOn)) else $error("low buzzer not started");
	buz_lo_off_a: assert property (cmd && usbRxData == 8'h74 |-> ##2 !buzzerLowOn)
		else $error("low buzzer not stopped");
	one_sound_a: assert property ($onehot0(snd))
		else $error("two sounds at once");
	tx_hold_a: assert property (usbTxValid && !usbTxReady |=> usbTxValid
		&& $stable(usbTxData)) else $error("report byte dropped while stalled");
	cover property (buzzerHighOn);
	cover property (clickLowOn);
	cover property (usbTxValid && !usbTxReady);
endmodule

//--- sim/tpc_host_model.sv
// Host side model: report sink and serial command sender
`include "tpc_defs.vh"
module tpc_host_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Report sink
	input wire logic [7:0] usbTxData,
	input wire logic usbTxValid,
	output logic usbTxReady,
	input wire logic stall,
	// Serial lines
	input wire logic serialTx,
	output logic serialRx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rxBytes[$];
	initial serialRx = 1'b1;
	// Random stalls when asked, else always ready
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			usbTxReady <= 1'b0;
		end else begin
			if (usbTxValid && usbTxReady)
				rxBytes.push_back(usbTxData);
			usbTxReady <= stall ? 1'($urandom) : 1'b1;
		end
	end
	// One 8N1 frame, low bit first, 9600 baud
	task automatic sendSerial(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			serialRx <= fr[i];
			repeat (`TPC_BIT_CYC - 1) @(posedge ref_clk);
		end
	endtask
	// Catch one 8N1 report byte, middle of each bit
	task automatic recvSerial(output logic [7:0] b, output bit ok);
		int k;
		b = 8'h00;
		ok = 1'b0;
		for (k = 0; k < 8 * `TPC_BIT_CYC && serialTx !== 1'b0; k++)
			@(posedge ref_clk);
		repeat (`TPC_HALF_BIT_CYC) @(posedge ref_clk);
		if (serialTx === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (`TPC_BIT_CYC) @(posedge ref_clk);
				b[i] = serialTx;
			end
			repeat (`TPC_BIT_CYC) @(posedge ref_clk);
			ok = (serialTx === 1'b1);
		end
	endtask
endmodule

//--- sim/tpc_touch_panel_test.sv
// Self-checking bench for the touch panel block
`include "tpc_defs.vh"
module tpc_touch_panel_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rstn = 0, autoSw = 0, clickSw = 0, portSw = 1;
	logic pressed = 0, usbRxValid = 0, stall = 0;
	logic [9:0] tx = 0, ty = 0;
	logic [7:0] usbRxData = 0, code;
	wire serialRx, serialTx, usbTxReady, usbTxValid, displayOn, backlightOn;
	wire bh, bl, ch, cl;
	wire [7:0] usbTxData;
	wire [3:0] snd = {bh, bl, ch, cl};
	int numErrors = 0, numChecks = 0, n;
	time t0;
	bit ok;
	logic [7:0] codes [4] = '{8'h73, 8'h71, 8'h72, 8'h74};
	logic [3:0] exps [4] = '{4'h4, 4'h8, 4'h4, 4'h0};
	logic [7:0] dcodes [4] = '{8'h66, 8'h65, 8'h68, 8'h67};
	always #25 ref_clk = ~ref_clk;
	tpc_touch_panel #(.REPORT_CYC(40'hc8), .IDLE_CYC(40'h1f4),
		.CLICK_CYC(40'h14)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .autoBacklightOffSwitch(autoSw),
		.clickDefaultSwitch(clickSw), .reportPortSelectSwitch(portSw),
		.touchPressed(pressed), .touchX(tx), .touchY(ty),
		.serialRx(serialRx), .serialTx(serialTx), .usbRxData(usbRxData),
		.usbRxValid(usbRxValid), .usbTxData(usbTxData),
		.usbTxValid(usbTxValid), .usbTxReady(usbTxReady),
		.displayOn(displayOn), .backlightOn(backlightOn),
		.buzzerHighOn(bh), .buzzerLowOn(bl), .clickHighOn(ch),
		.clickLowOn(cl));
	tpc_host_model host (.ref_clk(ref_clk), .rstn(rstn),
		.usbTxData(usbTxData), .usbTxValid(usbTxValid),
		.usbTxReady(usbTxReady), .stall(stall), .serialTx(serialTx),
		.serialRx(serialRx));
	task automatic check(input string name, input logic [9:0] exp, got);
		numChecks++;
		if (exp !== got) begin
			numErrors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task reportAndStop;
		$display("checks %0d errors %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task tick(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	task cmd(input logic [7:0] b);
		@(posedge ref_clk);
		usbRxData <= b;
		usbRxValid <= 1'b1;
		@(posedge ref_clk);
		usbRxValid <= 1'b0;
		tick(5);
	endtask
	task doReset(input logic a, c);
		@(posedge ref_clk);
		rstn <= 1'b0;
		autoSw <= a;
		clickSw <= c;
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		tick(6);
	endtask
	task automatic waitFor(input int nb, sb);
		int k;
		for (k = 0; k < 5000; k++) begin
			if (sb >= 0 && snd[sb] === 1'b1 || sb < 0 && host.rxBytes.size() >= nb)
				break;
			tick(1);
		end
		if (k == 5000) begin
			numErrors++;
			$display("CHECK FAILED wait expected done seen timeout");
			reportAndStop;
		end
	endtask
	initial begin
		void'($urandom(7626));
		doReset(1'b0, 1'b1);
		clickSw <= 1'b0;
		check("display", 1, displayOn);
		check("backlight", 1, backlightOn);
		check("sound", 0, snd);
		check("txValid", 0, usbTxValid);
		for (int i = 0; i < 4; i++) begin
			cmd(codes[i]);
			check("sound", exps[i], snd);
		end
		repeat (8) begin
			code = 8'h80 | 8'($urandom);
			cmd(code);
			check("display", 1, displayOn);
			check("sound", 0, snd);
		end
		for (int i = 0; i < 4; i++) begin
			cmd(dcodes[i]);
			check("display", i[0], displayOn);
			tick(1);
			check("backlight", i[0], backlightOn);
			if (i == 0) begin
				pressed <= 1'b1;
				tick(30);
				check("display", 0, displayOn);
				pressed <= 1'b0;
				tick(600);
			end
		end
		host.rxBytes.delete();
		tx <= 10'h3ff;
		ty <= 10'($urandom);
		stall <= 1'b1;
		tick(3);
		t0 = $time;
		pressed <= 1'b1;
		waitFor(0, 1);
		waitFor(15, -1);
		pressed <= 1'b0;
		tick(1500);
		n = host.rxBytes.size();
		check("whole", 0, 10'(n % 5));
		// Frames start at least 200 cycles apart, 50 ns clock
		check("rate", 1, n / 5 <= ($time - t0) / 10000 + 1);
		check("repeat", 1, n >= 15);
		for (int f = 0; f < n / 5; f++) begin
			check("hdr", f == n / 5 - 1 ? 8'h10 : 8'h11, host.rxBytes[5 * f]);
			check("xHi", {6'h00, tx[9:8]}, host.rxBytes[5 * f + 1]);
			check("xLo", tx[7:0], host.rxBytes[5 * f + 2]);
			check("yHi", {6'h00, ty[9:8]}, host.rxBytes[5 * f + 3]);
			check("yLo", ty[7:0], host.rxBytes[5 * f + 4]);
		end
		host.rxBytes.delete();
		tick(600);
		check("quiet", 0, 10'(host.rxBytes.size()));
		cmd(8'h6a);
		cmd(8'h6b);
		pressed <= 1'b1;
		waitFor(0, 0);
		pressed <= 1'b0;
		tick(600);
		portSw <= 1'b0;
		tick(3);
		cmd(8'h73);
		check("sound", 0, snd);
		host.sendSerial(8'h71);
		tick(10);
		check("sound", 4'h8, snd);
		pressed <= 1'b1;
		host.recvSerial(code, ok);
		pressed <= 1'b0;
		check("serialStop", 1, ok);
		check("serialHdr", 8'h11, code);
		portSw <= 1'b1;
		tick(3);
		cmd(8'h72);
		check("sound", 0, snd);
		doReset(1'b1, 1'b0);
		tick(700);
		check("backlight", 0, backlightOn);
		check("display", 1, displayOn);
		cmd(8'h69);
		tick(2);
		check("backlight", 1, backlightOn);
		cmd(8'h65);
		tick(700);
		check("backlight", 1, backlightOn);
		reportAndStop;
	end
endmodule
bind tpc_touch_panel tpc_touch_panel_asserts #(.REPORT_CYC(REPORT_CYC),
	.IDLE_CYC(IDLE_CYC), .CLICK_CYC(CLICK_CYC)) chk (.ref_clk(ref_clk),
	.rstn(rstn), .autoBacklightOffSwitch(autoBacklightOffSwitch),
	.clickDefaultSwitch(clickDefaultSwitch),
	.reportPortSelectSwitch(reportPortSelectSwitch),
	.touchPressed(touchPressed), .touchX(touchX), .touchY(touchY),
	.serialRx(serialRx), .serialTx(serialTx), .usbRxData(usbRxData),
	.usbTxData(usbTxData), .usbRxValid(usbRxValid),
	.usbTxValid(usbTxValid), .usbTxReady(usbTxReady),
	.displayOn(displayOn), .backlightOn(backlightOn),
	.buzzerHighOn(buzzerHighOn), .buzzerLowOn(buzzerLowOn),
	.clickHighOn(clickHighOn), .clickLowOn(clickLowOn));
